// [design/bcc_control.sv]
// branch target cache control, tuning, lock stack and fill policy
`timescale 1ns/10ps
`default_nettype none

module bcc_control
	import bcc_pkg::*;
(
	input  wire logic        clock,          // system clock, 10 MHz
	input  wire logic        rst,            // synchronous reset, high
	input  wire logic [7:0]  sfr_addr,       // register address
	input  wire logic [7:0]  sfr_wdata,      // register write data
	input  wire logic        sfr_wr,         // register write strobe
	input  wire logic        sfr_rd,         // register read strobe
	output logic [7:0]       sfr_rdata,      // read data, next cycle
	input  wire logic        core_stall,     // core held by a miss
	input  wire logic        fill_done,      // fetched segment ready
	input  wire logic        fill_is_reti,   // segment is a reti target
	input  wire logic        fill_in_isr,    // fetch inside an isr
	input  wire logic        fill_is_table,  // segment from a table read
	input  wire logic        flash_wr_done,  // flash write or erase
	input  wire logic [16:0] flash_wr_addr,  // byte written or erased
	input  wire logic        flash_scratch,  // write targets scratchpad
	output logic             cache_fill,     // write segment to slot
	output logic [5:0]       fill_slot,      // slot for cache_fill
	output logic             fill_is_push,   // fill came from a push
	output logic             cache_flush,    // invalidate all slots
	output logic             inval_req,      // invalidate one address
	output logic [16:0]      inval_addr,     // address to invalidate
	output logic             cache_read_en,  // hits may be served
	output logic             prefetch_en,    // prefetch engine on
	output logic             fixed_rate,     // flash-rate delivery
	output logic             flash_block_write_en, // grouped commits
	output logic [2:0]       flash_group_bytes,    // bytes per commit
	output logic [5:0]       lock_pointer    // lock stack pointer
);

	typedef struct packed {
		logic        cache_write_en;
		logic        cache_read_en;
		logic        prefetch_en;
		logic        return_target_cache_en;
		logic        irq_routine_cache_en;
		logic        table_read_cache_en;
		logic        flash_block_write_en;
		logic [3:0]  miss_accum_low_bits;
		logic        replace_algo_sel;
		logic        table_read_fixed_slot;
		logic [1:0]  miss_penalty_threshold;
		logic        lock_push_en;
		logic [5:0]  lock_pointer;
		logic [11:0] accum;
		logic        accum_ovf;
		logic [2:0]  stall_cnt;
		logic [7:0]  rdata;
		logic        fill;
		logic [5:0]  slot;
		logic        push;
		logic        flush;
		logic        inval;
		logic [16:0] inval_addr;
	} bcc_ctrl_state_t;

	bcc_ctrl_state_t s;
	bcc_ctrl_state_t next_s;

	bcc_repl_if rp ();

	logic wr_ctrl;
	logic wr_tune;
	logic wr_accum;
	logic wr_lock;
	logic rd_accum;
	logic allowed;
	logic normal_fill;
	logic push_fill;
	logic fixed_fill;
	logic accum_wrap;

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
		hit = (a == t);
	endfunction

	// flush bit always reads zero
	function automatic logic [7:0] ctrl_image(input bcc_ctrl_state_t st);
		ctrl_image = {st.cache_write_en, st.cache_read_en,
			st.prefetch_en, 1'b0, st.return_target_cache_en,
			st.irq_routine_cache_en, st.table_read_cache_en,
			st.flash_block_write_en};
	endfunction

	function automatic logic [7:0] tune_image(input bcc_ctrl_state_t st);
		tune_image = {st.miss_accum_low_bits, st.replace_algo_sel,
			st.table_read_fixed_slot, st.miss_penalty_threshold};
	endfunction

	function automatic logic [7:0] accum_image(input bcc_ctrl_state_t st);
		accum_image = {st.accum_ovf, st.accum[11:5]};
	endfunction

	// pop bit always reads zero
	function automatic logic [7:0] lock_image(input bcc_ctrl_state_t st);
		lock_image = {st.lock_push_en, 1'b0, st.lock_pointer};
	endfunction

	// unmapped addresses read zero
	function automatic logic [7:0] read_mux(input bcc_ctrl_state_t st,
		input logic [7:0] a);
		read_mux = 8'h00;
		if (hit(a, ADDR_CTRL)) begin
			read_mux = ctrl_image(st);
		end else if (hit(a, ADDR_TUNE)) begin
			read_mux = tune_image(st);
		end else if (hit(a, ADDR_ACCUM)) begin
			read_mux = accum_image(st);
		end else if (hit(a, ADDR_LOCK)) begin
			read_mux = lock_image(st);
		end
	endfunction

	// every field not named here starts at zero
	function automatic bcc_ctrl_state_t reset_state();
		bcc_ctrl_state_t r;
		r = '0;
		r.cache_write_en = CTRL_RESET[CTL_WR_EN];
		r.cache_read_en  = CTRL_RESET[CTL_RD_EN];
		r.prefetch_en    = CTRL_RESET[CTL_PF_EN];
		r.return_target_cache_en = CTRL_RESET[CTL_RETI_EN];
		r.irq_routine_cache_en   = CTRL_RESET[CTL_ISR_EN];
		r.table_read_cache_en    = CTRL_RESET[CTL_MOV_EN];
		r.flash_block_write_en   = CTRL_RESET[CTL_BLKW];
		r.replace_algo_sel       = TUNE_RESET[TUN_ALGO];
		r.table_read_fixed_slot  = TUNE_RESET[TUN_FIXED];
		r.miss_penalty_threshold = TUNE_RESET[1:0];
		r.lock_pointer = PTR_RESET;
		reset_state = r;
	endfunction

	// bytes per flash commit; pairs for scratchpad, quads for code
	function automatic logic [2:0] group_size(input logic blk,
		input logic scratch);
		if (!blk) begin
			group_size = GRP_SINGLE;
		end else if (scratch) begin
			group_size = GRP_SCRATCH;
		end else begin
			group_size = GRP_CODE;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// register decode

	assign wr_ctrl  = sfr_wr && hit(sfr_addr, ADDR_CTRL);
	assign wr_tune  = sfr_wr && hit(sfr_addr, ADDR_TUNE);
	assign wr_accum = sfr_wr && hit(sfr_addr, ADDR_ACCUM);
	assign wr_lock  = sfr_wr && hit(sfr_addr, ADDR_LOCK);
	assign rd_accum = sfr_rd && hit(sfr_addr, ADDR_ACCUM);

	////////////////////////////////////////////////////////////////////////
	// fill policy

	always_comb begin
		allowed = (s.stall_cnt > {1'b0, s.miss_penalty_threshold});
		if (fill_is_reti && !s.return_target_cache_en) begin
			allowed = 1'b0;
		end
		if (fill_in_isr && !s.irq_routine_cache_en) begin
			allowed = 1'b0;
		end
		if (fill_is_table && !s.table_read_cache_en) begin
			allowed = 1'b0;
		end
	end

	// push ignores write enable and the caching filters
	assign push_fill = fill_done && fill_is_table && s.lock_push_en;
	assign normal_fill = fill_done && !push_fill && allowed
		&& s.cache_write_en;
	assign fixed_fill = normal_fill && fill_is_table
		&& s.table_read_fixed_slot;

	// whole cache unlocked when the pointer sits at zero
	assign rp.limit = (s.lock_pointer == 6'h00) ? SLOT_TOP
		: s.lock_pointer;
	assign rp.algo_sel = s.replace_algo_sel;
	// fixed-slot table fills leave the sweep where it is
	assign rp.advance  = normal_fill && !fixed_fill;

	// a stall while the accumulator is full marks an overflow
	assign accum_wrap = core_stall && (s.accum == ACC_MAX);

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_s = s;
		next_s.fill  = 1'b0;
		next_s.push  = 1'b0;
		next_s.flush = 1'b0;
		next_s.inval = 1'b0;

		// control register
		if (wr_ctrl) begin
			next_s.cache_write_en = sfr_wdata[CTL_WR_EN];
			next_s.cache_read_en  = sfr_wdata[CTL_RD_EN];
			next_s.prefetch_en    = sfr_wdata[CTL_PF_EN];
			next_s.return_target_cache_en = sfr_wdata[CTL_RETI_EN];
			next_s.irq_routine_cache_en   = sfr_wdata[CTL_ISR_EN];
			next_s.table_read_cache_en    = sfr_wdata[CTL_MOV_EN];
			next_s.flash_block_write_en   = sfr_wdata[CTL_BLKW];
			next_s.flush = sfr_wdata[CTL_FLUSH];
		end

		// tuning register; upper nibble is not writable
		if (wr_tune) begin
			next_s.replace_algo_sel      = sfr_wdata[TUN_ALGO];
			next_s.table_read_fixed_slot = sfr_wdata[TUN_FIXED];
			next_s.miss_penalty_threshold = sfr_wdata[1:0];
		end

		// miss penalty accumulator
		if (core_stall) begin
			next_s.accum = 12'(s.accum + 12'h001);
		end
		if (wr_accum) begin
			next_s.accum = {sfr_wdata[6:0], 5'h00};
			next_s.accum_ovf = 1'b0;
		end
		// overflow set wins over the clearing write
		if (accum_wrap) begin
			next_s.accum_ovf = 1'b1;
		end
		if (rd_accum) begin
			next_s.miss_accum_low_bits = s.accum[4:1];
		end

		// stall length of the current miss
		// saturates so a long miss still counts as long
		if (fill_done) begin
			next_s.stall_cnt = 3'h0;
		end else if (core_stall && s.stall_cnt != STALL_MAX) begin
			next_s.stall_cnt = 3'(s.stall_cnt + 3'h1);
		end

		// lock stack
		if (wr_lock) begin
			next_s.lock_push_en = sfr_wdata[LCK_PUSH];
		end
		if (push_fill) begin
			next_s.fill = 1'b1;
			next_s.push = 1'b1;
			next_s.slot = s.lock_pointer;
			next_s.lock_pointer = 6'(s.lock_pointer - 6'h01);
		end else if (normal_fill) begin
			next_s.fill = 1'b1;
			next_s.slot = fixed_fill ? SLOT_FIXED : rp.slot;
		end
		// contents untouched; only the pointer moves
		// a push and a pop in one cycle leave the pointer in place
		if (wr_lock && sfr_wdata[LCK_POP]) begin
			next_s.lock_pointer = 6'(next_s.lock_pointer + 6'h01);
		end

		// flash writes invalidate whatever the write enable says
		if (flash_wr_done) begin
			next_s.inval = 1'b1;
			next_s.inval_addr = flash_wr_addr;
		end

		// read data holds until the next read strobe
		if (sfr_rd) begin
			next_s.rdata = read_mux(s, sfr_addr);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clock) begin
		if (rst) begin
			s <= reset_state();
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// slot picker

	bcc_replace u_replace (
		.clock (clock),
		.rst   (rst),
		.rp    (rp.repl)
	);

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign sfr_rdata     = s.rdata;
	assign cache_fill    = s.fill;
	assign fill_slot     = s.slot;
	assign fill_is_push  = s.push;
	assign cache_flush   = s.flush;
	assign inval_req     = s.inval;
	assign inval_addr    = s.inval_addr;
	assign cache_read_en = s.cache_read_en;
	assign prefetch_en   = s.prefetch_en;
	// flash-rate delivery is a decode of two registered enables
	assign fixed_rate    = !s.prefetch_en && !s.cache_read_en;
	assign flash_block_write_en = s.flash_block_write_en;
	assign flash_group_bytes = group_size(s.flash_block_write_en,
		flash_scratch);
	assign lock_pointer  = s.lock_pointer;

endmodule

`default_nettype wire

// [design/bcc_pkg.sv]
// shared constants for the branch cache control block
package bcc_pkg;

	// register addresses on the special-function register port
	localparam logic [7:0] ADDR_CTRL  = 8'ha1;
	localparam logic [7:0] ADDR_TUNE  = 8'ha2;
	localparam logic [7:0] ADDR_ACCUM = 8'h9a;
	localparam logic [7:0] ADDR_LOCK  = 8'ha3;

	// reset values
	localparam logic [7:0] CTRL_RESET = 8'he6;
	localparam logic [7:0] TUNE_RESET = 8'h04;
	localparam logic [5:0] PTR_RESET  = 6'h3e;
	localparam logic [5:0] LFSR_SEED  = 6'h01;

	// cache_control bit positions
	localparam int CTL_WR_EN   = 7;
	localparam int CTL_RD_EN   = 6;
	localparam int CTL_PF_EN   = 5;
	localparam int CTL_FLUSH   = 4;
	localparam int CTL_RETI_EN = 3;
	localparam int CTL_ISR_EN  = 2;
	localparam int CTL_MOV_EN  = 1;
	localparam int CTL_BLKW    = 0;

	// cache_tuning bit positions
	localparam int TUN_ALGO  = 3;
	localparam int TUN_FIXED = 2;

	// lock control bit positions
	localparam int LCK_PUSH = 7;
	localparam int LCK_POP  = 6;

	// slot geometry, flash commit group sizes and counter limits
	localparam logic [5:0] SLOT_TOP   = 6'h3e;
	localparam logic [5:0] SLOT_FIXED = 6'h00;
	localparam logic [2:0] GRP_CODE   = 3'h4;
	localparam logic [2:0] GRP_SCRATCH = 3'h2;
	localparam logic [2:0] GRP_SINGLE = 3'h1;
	localparam logic [2:0] STALL_MAX  = 3'h7;
	localparam logic [11:0] ACC_MAX   = 12'hfff;

endpackage

// [design/bcc_repl_if.sv]
// replacement request and answer between control and slot picker
`timescale 1ns/10ps
`default_nettype none

interface bcc_repl_if;
	logic       algo_sel;
	logic [5:0] limit;
	logic       advance;
	logic [5:0] slot;

	modport ctrl (output algo_sel, output limit, output advance,
		input slot);
	modport repl (input algo_sel, input limit, input advance,
		output slot);
endinterface

`default_nettype wire

// [design/bcc_replace.sv]
// slot picker: rebound sweep and pseudo-random replacement
`timescale 1ns/10ps
`default_nettype none

module bcc_replace
	import bcc_pkg::*;
(
	input  wire logic clock,   // system clock
	input  wire logic rst,     // synchronous reset, high
	bcc_repl_if.repl  rp       // request and answer
);

	typedef struct packed {
		logic [5:0] sweep;
		logic       down;
		logic [5:0] lfsr;
	} bcc_repl_state_t;

	bcc_repl_state_t s;
	bcc_repl_state_t next_s;
	logic [5:0]      rnd;
	logic [5:0]      swp;

	always_comb begin
		next_s = s;
		// free running every cycle
		next_s.lfsr = {s.lfsr[4:0], s.lfsr[5] ^ s.lfsr[4]};
		// sweep clamped when the lock pointer shrinks the range
		swp = (s.sweep > rp.limit) ? rp.limit : s.sweep;
		// fold an index above the unlocked range back into it
		rnd = s.lfsr;
		if (rnd > rp.limit) begin
			rnd = 6'(rnd - rp.limit - 6'h01);
			if (rnd > rp.limit) begin
				rnd = rp.limit;
			end
		end
		if (rp.advance && !rp.algo_sel) begin
			if (rp.limit == 6'h00) begin
				next_s.sweep = 6'h00;
			end else if (!s.down) begin
				if (swp >= rp.limit) begin
					next_s.down  = 1'b1;
					next_s.sweep = 6'(swp - 6'h01);
				end else begin
					next_s.sweep = 6'(swp + 6'h01);
				end
			end else begin
				if (swp == 6'h00) begin
					next_s.down  = 1'b0;
					next_s.sweep = 6'h01;
				end else begin
					next_s.sweep = 6'(swp - 6'h01);
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s <= '{sweep: 6'h00, down: 1'b0, lfsr: LFSR_SEED};
		end else begin
			s <= next_s;
		end
	end

	assign rp.slot = rp.algo_sel ? rnd : swp;

endmodule

`default_nettype wire

// [sim/bcc_control_asserts.sv]
// port assertions for the branch cache control block
`timescale 1ns/10ps
`default_nettype none

module bcc_control_chk
	import bcc_pkg::*;
(
	input wire logic        clock,                // clk
	input wire logic        rst,                  // rst
	input wire logic [7:0]  sfr_addr,             // in
	input wire logic [7:0]  sfr_wdata,            // in
	input wire logic        sfr_wr,               // in
	input wire logic        fill_done,            // in
	input wire logic        fill_is_reti,         // in
	input wire logic        fill_in_isr,          // in
	input wire logic        fill_is_table,        // in
	input wire logic        flash_wr_done,        // in
	input wire logic [16:0] flash_wr_addr,        // in
	input wire logic        flash_scratch,        // in
	input wire logic        cache_fill,           // out
	input wire logic [5:0]  fill_slot,            // out
	input wire logic        fill_is_push,         // out
	input wire logic        cache_flush,          // out
	input wire logic        inval_req,            // out
	input wire logic [16:0] inval_addr,           // out
	input wire logic        cache_read_en,        // out
	input wire logic        prefetch_en,          // out
	input wire logic        fixed_rate,           // out
	input wire logic        flash_block_write_en, // out
	input wire logic [2:0]  flash_group_bytes,    // out
	input wire logic [5:0]  lock_pointer          // out
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	logic [7:0] sh_c;
	logic       sh_fix;
	logic       sh_push;
	////////////////////////////////////////////////////////////////////
	// shadow of the written control bits
	always_ff @(posedge clock) begin
		if (rst) begin
			sh_c <= 8'he6;
			sh_fix <= 1'b1;
			sh_push <= 1'b0;
		end else if (sfr_wr) begin
			if (sfr_addr == ADDR_CTRL) sh_c <= sfr_wdata;
			if (sfr_addr == ADDR_TUNE) sh_fix <= sfr_wdata[TUN_FIXED];
			if (sfr_addr == ADDR_LOCK) sh_push <= sfr_wdata[LCK_PUSH];
		end
	end
	////////////////////////////////////////////////////////////////////
	sequence s_norm; fill_done && !(fill_is_table && sh_push); endsequence
	sequence s_pop; sfr_wr && sfr_addr == ADDR_LOCK && sfr_wdata[LCK_POP];
	endsequence
	sequence s_flw; sfr_wr && sfr_addr == ADDR_CTRL; endsequence
	flush_pulse_a: assert property (
		s_flw ##0 sfr_wdata[CTL_FLUSH] |=> cache_flush)
		else $error("flush pulse missing");
	inval_follow_a: assert property (
		flash_wr_done |=> inval_req && inval_addr == $past(flash_wr_addr))
		else $error("invalidate not issued");
	wr_block_a: assert property (
		s_norm ##0 !sh_c[CTL_WR_EN] |=> !cache_fill)
		else $error("fill with writes off");
	reti_block_a: assert property (
		s_norm ##0 (fill_is_reti && !sh_c[CTL_RETI_EN]) |=> !cache_fill)
		else $error("reti target cached");
	isr_block_a: assert property (
		s_norm ##0 (fill_in_isr && !sh_c[CTL_ISR_EN]) |=> !cache_fill)
		else $error("isr code cached");
	table_block_a: assert property (
		s_norm ##0 (fill_is_table && !sh_c[CTL_MOV_EN]) |=> !cache_fill)
		else $error("table data cached");
	fixed_slot_a: assert property (
		s_norm ##0 (fill_is_table && sh_fix) |=>
		!cache_fill || fill_slot == SLOT_FIXED)
		else $error("table fill not in slot 0");
	push_slot_a: assert property (
		fill_done && fill_is_table && sh_push |=> cache_fill
		&& fill_is_push && fill_slot == $past(lock_pointer))
		else $error("push fill wrong");
	pop_step_a: assert property (
		s_pop ##0 !fill_done |=> lock_pointer == $past(lock_pointer) + 6'h1)
		else $error("pop did not step pointer");
	locked_skip_a: assert property (
		cache_fill && !fill_is_push && lock_pointer != 6'h00 |->
		fill_slot <= lock_pointer)
		else $error("locked slot replaced");
	levels_a: assert property (
		{cache_read_en, prefetch_en, flash_block_write_en} ==
		{sh_c[CTL_RD_EN], sh_c[CTL_PF_EN], sh_c[CTL_BLKW]})
		else $error("enable levels wrong");
	rate_a: assert property (
		fixed_rate == (!cache_read_en && !prefetch_en))
		else $error("fixed rate wrong");
	group_a: assert property (
		flash_group_bytes == (!flash_block_write_en ? GRP_SINGLE :
		flash_scratch ? GRP_SCRATCH : GRP_CODE))
		else $error("group size wrong");
endmodule

bind bcc_control bcc_control_chk i_chk (.clock, .rst, .sfr_addr,
	.sfr_wdata, .sfr_wr, .fill_done, .fill_is_reti, .fill_in_isr,
	.fill_is_table, .flash_wr_done, .flash_wr_addr, .flash_scratch,
	.cache_fill, .fill_slot, .fill_is_push, .cache_flush, .inval_req,
	.inval_addr, .cache_read_en, .prefetch_en, .fixed_rate,
	.flash_block_write_en, .flash_group_bytes, .lock_pointer);

`default_nettype wire

// [sim/bcc_core_model.sv]
// core fetch and flash write model facing the cache control block
`timescale 1ns/10ps
`default_nettype none

module bcc_core_model (
	input  wire logic   clock,         // system clock
	output logic        core_stall,    // miss stall
	output logic        fill_done,     // segment ready
	output logic        fill_is_reti,  // reti target
	output logic        fill_in_isr,   // inside isr
	output logic        fill_is_table, // table read
	output logic        flash_wr_done, // flash write pulse
	output logic [16:0] flash_wr_addr, // byte address
	output logic        flash_scratch  // scratchpad target
);
	initial begin
		{core_stall, fill_done, flash_wr_done, flash_scratch} = 4'h0;
		{fill_is_reti, fill_in_isr, fill_is_table} = 3'h0;
		flash_wr_addr = 17'h0;
	end
	// stall n cycles, then hand over one segment
	task automatic miss(input int n, input logic [2:0] q);
		repeat (n) begin
			@(posedge clock) #1;
			core_stall = 1'b1;
		end
		@(posedge clock) #1;
		core_stall = 1'b0;
		fill_done = 1'b1;
		{fill_is_reti, fill_in_isr, fill_is_table} = q;
		@(posedge clock) #1;
		fill_done = 1'b0;
		// qualifiers mean nothing outside fill_done
		{fill_is_reti, fill_in_isr, fill_is_table} = ~q;
	endtask
	task automatic fwrite(input logic [16:0] a, input logic s);
		@(posedge clock) #1;
		{flash_wr_done, flash_wr_addr, flash_scratch} = {1'b1, a, s};
		@(posedge clock) #1;
		flash_wr_done = 1'b0;
		flash_wr_addr = ~a;
	endtask
endmodule

`default_nettype wire

// [sim/tb.sv]
// self-checking bench for the branch cache control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((e) !== (s)) begin \
	n_errors++; $display("BAD %s exp %h got %h", nm, e, s); end end

module tb;
	import bcc_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_rdata, c;
	logic core_stall, fill_done, fill_is_reti, fill_in_isr, fill_is_table;
	logic flash_wr_done, flash_scratch, cache_fill, fill_is_push;
	logic cache_flush, inval_req, cache_read_en, prefetch_en, fixed_rate;
	logic flash_block_write_en;
	logic [16:0] flash_wr_addr, inval_addr, a;
	logic [5:0] fill_slot, lock_pointer;
	logic [2:0] flash_group_bytes, q, lv;
	logic [3:0] t;
	int n_errors = 0;
	int n_compared = 0;
	int n;
	integer seed = 32'ha5d6b62f;
	logic [7:0] ra[5] = '{ADDR_CTRL, ADDR_TUNE, ADDR_LOCK, ADDR_ACCUM, 8'h55};
	logic [7:0] rv[5] = '{8'he6, 8'h04, 8'h3e, 8'h00, 8'h00};
	logic [5:0] sw[6] = '{6'h00, 6'h01, 6'h02, 6'h01, 6'h00, 6'h01};

	bcc_control i_dut (.clock, .rst, .sfr_addr, .sfr_wdata, .sfr_wr,
		.sfr_rd, .sfr_rdata, .core_stall, .fill_done, .fill_is_reti,
		.fill_in_isr, .fill_is_table, .flash_wr_done, .flash_wr_addr,
		.flash_scratch, .cache_fill, .fill_slot, .fill_is_push,
		.cache_flush, .inval_req, .inval_addr, .cache_read_en,
		.prefetch_en, .fixed_rate, .flash_block_write_en,
		.flash_group_bytes, .lock_pointer);
	bcc_core_model i_core (.clock, .core_stall, .fill_done, .fill_is_reti,
		.fill_in_isr, .fill_is_table, .flash_wr_done, .flash_wr_addr,
		.flash_scratch);

	always #50 clock = ~clock;
	////////////////////////////////////////////////////////////////////
	function automatic logic exp_fill(logic [7:0] r, logic [1:0] h, int k,
		logic [2:0] u);
		return k > h && r[CTL_WR_EN] && (!u[2] || r[CTL_RETI_EN])
			&& (!u[1] || r[CTL_ISR_EN]) && (!u[0] || r[CTL_MOV_EN]);
	endfunction
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge clock) #1;
		{sfr_addr, sfr_wdata, sfr_wr} = {ad, d, 1'b1};
		@(posedge clock) #1;
		sfr_wr = 1'b0;
	endtask
	task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
		@(posedge clock) #1;
		{sfr_addr, sfr_rd} = {ad, 1'b1};
		@(posedge clock) #1;
		sfr_rd = 1'b0;
		`CHK("sfr_rdata", e, sfr_rdata)
	endtask
	task automatic fchk(input int k, input logic [2:0] u, input logic e);
		i_core.miss(k, u);
		`CHK("cache_fill", e, cache_fill)
	endtask
	task automatic results;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (100000) @(posedge clock);
		n_errors++;
		results;
	end
	initial begin
		repeat (16) @(posedge clock);
		#1;
		rst = 1'b0;
		foreach (ra[k]) rchk(ra[k], rv[k]);
		i_core.miss(10, 3'h0);
		rchk(ADDR_ACCUM, 8'h00);
		rchk(ADDR_TUNE, 8'h54);
		wr(ADDR_ACCUM, 8'h01);
		rchk(ADDR_ACCUM, 8'h01);
		wr(ADDR_TUNE, 8'hf4);
		rchk(ADDR_TUNE, 8'h04);
		wr(ADDR_ACCUM, 8'h7f);
		i_core.miss(40, 3'h0);
		rchk(ADDR_ACCUM, 8'h80);
		wr(ADDR_CTRL, 8'hf6);
		`CHK("cache_flush", 1'b1, cache_flush)
		rchk(ADDR_CTRL, 8'he6);
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_CTRL, k[0] ? 8'he7 : 8'h66);
			a = 17'($random(seed));
			i_core.fwrite(a, k[1]);
			`CHK("inval", {1'b1, a}, {inval_req, inval_addr})
			n = !k[0] ? 1 : k[1] ? 2 : 4;
			`CHK("group", n[2:0], flash_group_bytes)
		end
		wr(ADDR_CTRL, 8'he6);
		wr(ADDR_TUNE, 8'h02);
		fchk(2, 3'h0, 1'b0);
		fchk(3, 3'h0, 1'b1);
		for (int k = 0; k < 40; k++) begin
			c = 8'($random(seed)) & 8'hef;
			t = 4'($random(seed));
			n = ($random(seed) & 7) % 5;
			q = 3'($random(seed));
			wr(ADDR_CTRL, c);
			wr(ADDR_TUNE, {4'h0, t});
			lv = {cache_read_en, prefetch_en, fixed_rate};
			`CHK("levels", {c[6:5], ~|c[6:5]}, lv)
			fchk(n, q, exp_fill(c, t[1:0], n, q));
			if (cache_fill === 1'b1 && q[0] && t[2])
				`CHK("fixed", SLOT_FIXED, fill_slot)
		end
		wr(ADDR_CTRL, 8'h66);
		wr(ADDR_LOCK, 8'h80);
		i_core.miss(0, 3'h1);
		`CHK("push", 8'hfe, {cache_fill, fill_is_push, fill_slot})
		rchk(ADDR_LOCK, 8'hbd);
		wr(ADDR_LOCK, 8'h40);
		rchk(ADDR_LOCK, 8'h3e);
		@(posedge clock) #1;
		rst = 1'b1;
		repeat (2) @(posedge clock);
		#1;
		rst = 1'b0;
		wr(ADDR_LOCK, 8'h80);
		repeat (60) i_core.miss(0, 3'h1);
		wr(ADDR_LOCK, 8'h00);
		`CHK("lock_pointer", 6'h02, lock_pointer)
		foreach (sw[k]) begin
			i_core.miss(1, 3'h0);
			`CHK("rebound", sw[k], fill_slot)
		end
		wr(ADDR_TUNE, 8'h08);
		repeat (8) begin
			i_core.miss(1, 3'h0);
			`CHK("random", 1'b1, cache_fill && fill_slot <= 6'h02)
		end
		results;
	end
endmodule

`default_nettype wire
